// ===== src/irq_agg_defs.vh
`ifndef IRQ_AGG_DEFS_VH
`define IRQ_AGG_DEFS_VH

// register offset in i/o space
`define IRQ_MASK_ADDR 8'h04
// number of maskable sources
`define IRQ_NUM_SRC 6
// reset value of the enable mask
`define IRQ_MASK_RST 6'h00
// vector base, each source two above the one before
`define IRQ_VEC_BASE 8'hf0
// field positions of the sources in the mask and status bytes
`define IRQ_BIT_ALARM 0
`define IRQ_BIT_SERIAL 1
`define IRQ_BIT_CARRIER 2
`define IRQ_BIT_CAPTURE 3
`define IRQ_BIT_WRAP 4
`define IRQ_BIT_OPTION 5

`endif

// ===== src/src_sync.v
`timescale 1ns/100ps

// three-flop synchroniser, change accepted once stages two and three agree
module src_sync #(
    parameter WIDTH = 4
) (
    input wire clk_i, // system clock
    input wire rst_n_i, // synchronous reset, active low
    input wire [WIDTH-1:0] async_i, // raw pin levels
    output reg [WIDTH-1:0] sync_o // filtered levels
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] mid_ff;
reg [WIDTH-1:0] last_ff;
genvar gi;

// ----------------------------------------
// per-bit synchroniser stages
// ----------------------------------------
generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
        always @(posedge clk_i) begin
            if (!rst_n_i) begin
                meta_ff[gi] <= 1'b0;
                mid_ff[gi] <= 1'b0;
                last_ff[gi] <= 1'b0;
                sync_o[gi] <= 1'b0;
            end else begin
                meta_ff[gi] <= async_i[gi];
                mid_ff[gi] <= meta_ff[gi];
                last_ff[gi] <= mid_ff[gi];
                if (mid_ff[gi] == last_ff[gi]) begin
                    sync_o[gi] <= last_ff[gi]; // stages agree
                end
            end
        end
    end
endgenerate

endmodule // src_sync

// ===== src/vectored_irq_aggregator.v
`timescale 1ns/100ps
`include "irq_agg_defs.vh"

// Behaviour
// - six sources merged into one active-low request
// - sources 3 and 4 generated internally
// - write to 0004 loads enable mask
// - vectors F0 F2 F4 F6 F8 FA
// - fixed priority, source 0 highest, takeover above
// - source order: alarm serial carrier capture wrap option
// - enabled pending source requests; cpu finishes instruction
// - vector byte returned for mode-2 indirect call
// - vector driven on data bus during acknowledge
module vectored_irq_aggregator #(
    parameter NSRC = `IRQ_NUM_SRC
) (
    input wire clk_i, // processor clock
    input wire rst_n_i, // synchronous reset, active low
    input wire [7:0] addr_i, // i/o address, low byte
    input wire [7:0] data_i, // data bus from cpu
    output reg [7:0] data_o, // data bus to cpu
    output reg data_oe_o, // data bus drive enable
    input wire io_request_strobe_n_i, // i/o request, active low
    input wire read_strobe_n_i, // read strobe, active low
    input wire write_strobe_n_i, // write strobe, active low
    input wire opcode_fetch_cycle_n_i, // opcode fetch, active low
    input wire source_0_alarm_i, // alarm or low voltage, level
    input wire source_1_serial_rx_i, // byte received, level
    input wire source_2_carrier_i, // carrier detect, level
    input wire source_5_option_i, // option unit, level
    input wire capture_flag_i, // capture event pulse
    input wire counter_wrap_flag_i, // counter overflow pulse
    input wire capture_clr_i, // capture flag cleared
    input wire wrap_clr_i, // overflow flag cleared
    input wire bus_takeover_request_n_i, // option unit takeover, active low
    output reg cpu_service_request_n_o, // merged request, active low
    output reg bus_takeover_request_n_o, // takeover passed to cpu
    output reg nmi_request_n_o // non-maskable request, held idle
);

// ----------------------------------------
// declarations
// ----------------------------------------
// one-hot bus cycle states
localparam ST_IDLE = 3'b001; // no cycle on the bus
localparam ST_ACK = 3'b010; // acknowledge fetch under way
localparam ST_READ = 3'b100; // status read under way
// sources raised inside this block
localparam NEVT = 2;

// synchronised external sources
wire [3:0] ext_sync;

// enable mask and write strobe history
reg [NSRC-1:0] source_mask_bits_ff;
reg [NSRC-1:0] nxt_source_mask_bits;
reg wr_d_ff;

// internal event flags, bit 0 capture, bit 1 wrap
wire [NEVT-1:0] evt_set;
wire [NEVT-1:0] evt_clr;
reg [NEVT-1:0] evt_flag_ff;
wire source_3_capture;
wire source_4_wrap;

// pending, enabled and winning sources
wire [NSRC-1:0] pending_source_flags;
wire [NSRC-1:0] active_src;
wire any_active;
reg [7:0] vec_sel;
integer k;

// bus decode
wire reg_hit;
wire wr_now;
wire rd_now;
wire ack_now;

// bus cycle tracking
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [7:0] vec_hold_ff;
reg [7:0] nxt_vec_hold;

// data bus next state
reg [7:0] nxt_data;
reg nxt_oe;
genvar gf;

// ----------------------------------------
// external source synchronisers
// ----------------------------------------
// pins from other boards, three flops per source
src_sync #(
    .WIDTH(4)
) src_sync_i (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({source_5_option_i, source_2_carrier_i, source_1_serial_rx_i, source_0_alarm_i}),
    .sync_o(ext_sync)
);

// ----------------------------------------
// internally generated sources
// ----------------------------------------
// event inputs and their clears, one pair per flag
assign evt_set = {counter_wrap_flag_i, capture_flag_i};
assign evt_clr = {wrap_clr_i, capture_clr_i};

// sticky flag per event, set wins over a clear in the same cycle
generate
    for (gf = 0; gf < NEVT; gf = gf + 1) begin : g_evt
        always @(posedge clk_i) begin
            if (!rst_n_i) begin
                evt_flag_ff[gf] <= 1'b0;
            end else if (evt_set[gf]) begin
                evt_flag_ff[gf] <= 1'b1;
            end else if (evt_clr[gf]) begin
                evt_flag_ff[gf] <= 1'b0;
            end
        end
    end
endgenerate

// flags as numbered sources
assign source_3_capture = evt_flag_ff[0];
assign source_4_wrap = evt_flag_ff[1];

// ----------------------------------------
// status byte and enabled sources
// ----------------------------------------
// status bits in source order
assign pending_source_flags[`IRQ_BIT_ALARM] = ext_sync[0];
assign pending_source_flags[`IRQ_BIT_SERIAL] = ext_sync[1];
assign pending_source_flags[`IRQ_BIT_CARRIER] = ext_sync[2];
assign pending_source_flags[`IRQ_BIT_CAPTURE] = source_3_capture;
assign pending_source_flags[`IRQ_BIT_WRAP] = source_4_wrap;
assign pending_source_flags[`IRQ_BIT_OPTION] = ext_sync[3];
// only enabled sources may request service
assign active_src = pending_source_flags & source_mask_bits_ff;
// any enabled source still pending
assign any_active = |active_src;

// ----------------------------------------
// bus decode
// ----------------------------------------
// register hit on the low address byte
assign reg_hit = (addr_i == `IRQ_MASK_ADDR);
// plain write and read cycles to the register
assign wr_now = !io_request_strobe_n_i && !write_strobe_n_i && reg_hit;
assign rd_now = !io_request_strobe_n_i && !read_strobe_n_i && reg_hit;
// acknowledge: opcode fetch together with i/o request
assign ack_now = !io_request_strobe_n_i && !opcode_fetch_cycle_n_i;

// ----------------------------------------
// enable mask register
// ----------------------------------------
// mask loads on the first cycle of a write strobe only
always @* begin
    nxt_source_mask_bits = source_mask_bits_ff;
    if (wr_now && !wr_d_ff) begin
        nxt_source_mask_bits = data_i[NSRC-1:0];
    end
end

// mask and write strobe history
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        source_mask_bits_ff <= `IRQ_MASK_RST;
        wr_d_ff <= 1'b0;
    end else begin
        source_mask_bits_ff <= nxt_source_mask_bits;
        wr_d_ff <= wr_now;
    end
end

// ----------------------------------------
// fixed priority vector select
// ----------------------------------------
// winner table: base plus twice the source number
always @* begin
    vec_sel = `IRQ_VEC_BASE;
    // scan lowest priority first so source 0 wins
    for (k = NSRC - 1; k >= 0; k = k - 1) begin
        if (active_src[k]) begin
            vec_sel = `IRQ_VEC_BASE + {k[6:0], 1'b0};
        end
    end
end

// ----------------------------------------
// bus cycle state machine
// ----------------------------------------
// vector frozen as the acknowledge opens, so a late source cannot change it mid-fetch
always @* begin
    nxt_state = state_ff;
    nxt_vec_hold = vec_hold_ff;
    case (state_ff)
        ST_IDLE: begin
            if (ack_now) begin
                nxt_state = ST_ACK;
                nxt_vec_hold = vec_sel;
            end else if (rd_now) begin
                nxt_state = ST_READ;
            end
        end
        ST_ACK: begin
            if (!ack_now && rd_now) begin
                nxt_state = ST_READ;
            end else if (!ack_now) begin
                nxt_state = ST_IDLE;
            end
        end
        ST_READ: begin
            if (ack_now) begin
                nxt_state = ST_ACK;
                nxt_vec_hold = vec_sel;
            end else if (!rd_now) begin
                nxt_state = ST_IDLE;
            end
        end
        default: begin
            nxt_state = ST_IDLE;
        end
    endcase
end

// state and frozen vector
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        state_ff <= ST_IDLE;
        vec_hold_ff <= `IRQ_VEC_BASE;
    end else begin
        state_ff <= nxt_state;
        vec_hold_ff <= nxt_vec_hold;
    end
end

// ----------------------------------------
// data bus
// ----------------------------------------
// acknowledge has priority over a status read
always @* begin
    nxt_data = 8'h00;
    nxt_oe = 1'b0;
    case (nxt_state)
        ST_ACK: begin
            nxt_data = nxt_vec_hold;
            nxt_oe = 1'b1;
        end
        ST_READ: begin
            nxt_data = {{(8-NSRC){1'b0}}, pending_source_flags};
            nxt_oe = 1'b1;
        end
        default: begin
            nxt_data = 8'h00;
            nxt_oe = 1'b0;
        end
    endcase
end

// bus pins straight from flops
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        data_o <= 8'h00;
        data_oe_o <= 1'b0;
    end else begin
        data_o <= nxt_data;
        data_oe_o <= nxt_oe;
    end
end

// ----------------------------------------
// request outputs
// ----------------------------------------
// merged request, low while any enabled source pends
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        cpu_service_request_n_o <= 1'b1;
    end else begin
        cpu_service_request_n_o <= ~any_active;
    end
end

// takeover passes on through one flop, a cycle later, it outranks every maskable source
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        bus_takeover_request_n_o <= 1'b1;
        nmi_request_n_o <= 1'b1;
    end else begin
        bus_takeover_request_n_o <= bus_takeover_request_n_i;
        nmi_request_n_o <= 1'b1;
    end
end

endmodule // vectored_irq_aggregator

// ===== testbench/irq_agg_asserts.sv
`timescale 1ns/100ps
module irq_agg_asserts (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic [7:0] addr_i, // addr
    input wire logic io_request_strobe_n_i, // io_request_strobe
    input wire logic read_strobe_n_i, // rd
    input wire logic opcode_fetch_cycle_n_i, // fetch
    input wire logic bus_takeover_request_n_i, // takeover in
    input wire logic [7:0] data_o, // data
    input wire logic data_oe_o, // enable
    input wire logic cpu_service_request_n_o, // request
    input wire logic bus_takeover_request_n_o, // takeover out
    input wire logic nmi_request_n_o // nmi
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // decoded acknowledge and read
    wire ack = !io_request_strobe_n_i && !opcode_fetch_cycle_n_i;
    wire rd = !io_request_strobe_n_i && !read_strobe_n_i && opcode_fetch_cycle_n_i;
    a_nmi_held_idle: assert property (nmi_request_n_o)
        else $error("nmi active");
    a_takeover_one_cycle: assert property ($past(rst_n_i) |-> bus_takeover_request_n_o == $past(bus_takeover_request_n_i))
        else $error("takeover lag");
    a_ack_gives_vector: assert property (ack |=> data_oe_o && data_o[7:4] == 4'hf && !data_o[0] && data_o[3:0] <= 4'ha)
        else $error("bad vector");
    a_status_upper_zero: assert property (rd && addr_i == 8'h04 |=> data_oe_o && data_o[7:6] == 2'b00)
        else $error("bad status");
    a_other_addr_quiet: assert property (rd && addr_i != 8'h04 |=> !data_oe_o)
        else $error("foreign read");
    a_release_drops_oe: assert property (io_request_strobe_n_i |=> !data_oe_o)
        else $error("oe held");
    a_req_idle_reset: assert property ($rose(rst_n_i) |-> cpu_service_request_n_o)
        else $error("request at reset");
    a_oe_needs_access: assert property ($rose(data_oe_o) |-> $past(ack || rd))
        else $error("oe unprompted");
    a_vector_held_steady: assert property (ack && $past(ack) |=> $stable(data_o))
        else $error("vector moved");
endmodule // irq_agg_asserts
bind vectored_irq_aggregator irq_agg_asserts irq_agg_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .io_request_strobe_n_i(io_request_strobe_n_i), .read_strobe_n_i(read_strobe_n_i),
    .opcode_fetch_cycle_n_i(opcode_fetch_cycle_n_i), .bus_takeover_request_n_i(bus_takeover_request_n_i),
    .data_o(data_o), .data_oe_o(data_oe_o), .cpu_service_request_n_o(cpu_service_request_n_o),
    .bus_takeover_request_n_o(bus_takeover_request_n_o), .nmi_request_n_o(nmi_request_n_o));

// ===== testbench/cpu_model.sv
`timescale 1ns/100ps
module cpu_model (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic req_n_i, // request
    input wire logic go_i, // allow one ack
    input wire logic [7:0] data_i, // bus
    output logic io_request_strobe_n_o = 1'b1, // io_request_strobe
    output logic m1_n_o = 1'b1, // fetch
    output logic [7:0] vec_o = 8'h00, // vector
    output logic done_o = 1'b0 // ack over
);
    logic [2:0] cnt_ff = 3'h0;
    // ack fetch: two states, two waits, vector latched as the third state opens
    always @(posedge clk_i) begin
        if (!rst_n_i || !go_i) begin
            cnt_ff <= 3'h0;
            io_request_strobe_n_o <= 1'b1;
            m1_n_o <= 1'b1;
            done_o <= 1'b0;
        end else if (cnt_ff == 3'h0 && !done_o && !req_n_i) begin
            cnt_ff <= 3'h1;
            io_request_strobe_n_o <= 1'b0;
            m1_n_o <= 1'b0;
        end else if (cnt_ff == 3'h4) begin
            vec_o <= data_i;
            cnt_ff <= 3'h0;
            io_request_strobe_n_o <= 1'b1;
            m1_n_o <= 1'b1;
            done_o <= 1'b1;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end
endmodule // cpu_model

// ===== testbench/vectored_irq_aggregator_tb.sv
`timescale 1ns/100ps
module vectored_irq_aggregator_tb;
    logic clk_i = 0, rst_n_i = 0, io_request_strobe_n = 1, rd_n = 1, wr_n = 1, go = 0, tko_n = 1;
    logic cap = 0, wrp = 0, cclr = 0, wclr = 0;
    logic [7:0] addr = 0, wdat = 0, got;
    logic [3:0] src = 0;
    wire [7:0] data_o, vec;
    wire oe, req_n, tko_o, nmi_n, m_io_request_strobe_n, m1_n, done;
    int failures = 0, comparisons = 0;
    // clock
    always #12.5 clk_i = ~clk_i;
    vectored_irq_aggregator vectored_irq_aggregator_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .data_i(wdat),
        .data_o(data_o), .data_oe_o(oe), .io_request_strobe_n_i(io_request_strobe_n & m_io_request_strobe_n), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .opcode_fetch_cycle_n_i(m1_n), .source_0_alarm_i(src[0]),
        .source_1_serial_rx_i(src[1]), .source_2_carrier_i(src[2]), .source_5_option_i(src[3]),
        .capture_flag_i(cap), .counter_wrap_flag_i(wrp), .capture_clr_i(cclr), .wrap_clr_i(wclr),
        .bus_takeover_request_n_i(tko_n), .cpu_service_request_n_o(req_n), .bus_takeover_request_n_o(tko_o),
        .nmi_request_n_o(nmi_n));
    cpu_model cpu_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_n_i(req_n), .go_i(go), .data_i(oe ? data_o : 8'hff),
        .io_request_strobe_n_o(m_io_request_strobe_n), .m1_n_o(m1_n), .vec_o(vec), .done_o(done));
    // compare and count
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // i/o cycle, read result in got
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) begin io_request_strobe_n <= 0; rd_n <= w; wr_n <= !w; addr <= a; wdat <= d; end
        repeat (2) @(posedge clk_i);
        #1 got = oe ? data_o : 8'hee;
        @(posedge clk_i) begin io_request_strobe_n <= 1; rd_n <= 1; wr_n <= 1; end
        @(posedge clk_i);
    endtask
    // one acknowledge by the processor model
    task automatic ack(input logic [7:0] e);
        int n;
        n = 0;
        go <= 1;
        while (done !== 1'b1 && n < 50) begin @(posedge clk_i); n++; end
        if (n == 50) begin failures++; complete_run; end
        check(vec, e);
        go <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    // verdict
    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1;
        @(posedge clk_i) begin src <= 4'hf; cap <= 1; wrp <= 1; end
        @(posedge clk_i) begin cap <= 0; wrp <= 0; end
        repeat (8) @(posedge clk_i);
        check({7'h0, req_n}, 8'h01);
        check({7'h0, nmi_n}, 8'h01);
        io(0, 8'h04, 0); check(got, 8'h3f);
        io(0, 8'h05, 0); check(got, 8'hee);
        $display("masked test done");
        for (int n = 5; n >= 0; n--) begin
            io(1, 8'h04, 8'hc0 | (8'h3f << n));
            repeat (8) @(posedge clk_i);
            check({7'h0, req_n}, 8'h00);
            ack(8'hf0 + 8'(2 * n));
        end
        $display("priority test done");
        @(posedge clk_i) begin src <= 0; cclr <= 1; wclr <= 1; end
        @(posedge clk_i) begin cclr <= 0; wclr <= 0; end
        repeat (8) @(posedge clk_i);
        check({7'h0, req_n}, 8'h01);
        io(0, 8'h04, 0); check(got, 8'h00);
        @(posedge clk_i) begin cap <= 1; cclr <= 1; end
        @(posedge clk_i) begin cap <= 0; cclr <= 0; end
        io(0, 8'h04, 0); check(got, 8'h08);
        @(posedge clk_i) tko_n <= 0;
        repeat (2) @(posedge clk_i);
        check({7'h0, tko_o}, 8'h00);
        @(posedge clk_i) tko_n <= 1;
        repeat (2) @(posedge clk_i);
        check({7'h0, tko_o}, 8'h01);
        $display("clear test done");
        complete_run;
    end
endmodule // vectored_irq_aggregator_tb
